// [logic/ptlc_pkg.sv]
// constants, types and field layout for the port trigger and legacy control bank
// Operation
// R01: reclassify bit launches one classification, upper nibble
// R02: reclassify bit self-clears when classification finishes
// R03: redetect bit launches one detection, lower nibble
// R04: redetect bit self-clears when detection finishes
// R05: manual mode runs trigger once, only after write
// R06: other modes repeat under detection/classification enables
// R07: power-off bit shuts port, then self-clears
// R08: power-on bit starts port, clears on start-up done
// R09: detection enable with power-on: detect first
// R10: manual power-on ignored when powered or shutdown
// R11: semi-auto power-on needs valid detect/class results
// R12: auto power-on only during legacy detection
// R13: power-on cleared on failures or 400ms timeout
// R14: legacy codes: off, instead, after, reserved
// R15: one legacy field per port, reset disabled
// R16: reserved legacy code behaves as disabled
// R17: host relies on auto-clear; zero writes ignored
package ptlc_pkg;

    // ==========================================================
    // register map
    localparam logic [7:0] OFF_DET_CLS_TRIG = 8'h10; // detect_classify_trigger
    localparam logic [7:0] OFF_POWER_TRIG   = 8'h11; // power_on_off_trigger
    localparam logic [7:0] OFF_LEGACY_EN    = 8'h12; // legacy_detect_enable
    localparam logic [7:0] RESET_BYTE       = 8'h00; // reset value of all three
    localparam logic [7:0] READ_UNMAPPED    = 8'h00; // answer to unknown offsets
    localparam logic [3:0] NIBBLE_ZERO      = 4'h0;

    // ==========================================================
    // field positions
    localparam int UPPER_MSB = 7; // reclassify / power-off nibble
    localparam int UPPER_LSB = 4;
    localparam int LOWER_MSB = 3; // redetect / power-on nibble
    localparam int LOWER_LSB = 0;
    localparam int PORTS     = 4;
    localparam int LEG_W     = 2; // legacy field width per port

    // ==========================================================
    // legacy policy encodings
    localparam logic [1:0] LEG_OFF      = 2'h0; // legacy detection disabled
    localparam logic [1:0] LEG_INSTEAD  = 2'h1; // legacy replaces standard
    localparam logic [1:0] LEG_AFTER    = 2'h2; // legacy after standard
    localparam logic [1:0] LEG_RESERVED = 2'h3; // treated as disabled

    // ==========================================================
    // timing
    localparam int unsigned CLK_HZ       = 25_000_000;
    localparam int unsigned ON_TIMEOUT_MS = 400; // power-on request lifetime
    localparam int unsigned ON_TIMEOUT_CYCLES = ON_TIMEOUT_MS * (CLK_HZ / 1000);
    localparam int          TMO_W        = 24;   // counter width, holds 10 M

    // ==========================================================
    // types
    typedef enum logic [1:0] {
        PTLC_MANUAL,
        PTLC_SEMI_AUTO,
        PTLC_AUTO
    } ptlc_mode_t;

    // status reported by the per-port engines, one bit per port
    typedef struct packed {
        logic [3:0] det_done;      // detection cycle finished
        logic [3:0] cls_done;      // classification finished
        logic [3:0] start_done;    // start-up finished
        logic [3:0] det_fail;      // detection failure
        logic [3:0] cls_fail;      // classification failure
        logic [3:0] legacy_fail;   // legacy detection failure
        logic [3:0] start_fail;    // start-up failure
        logic [3:0] powered;       // port is powered / operational
        logic [3:0] shutdown;      // port is in shutdown
        logic [3:0] results_valid; // detection and class results valid
        logic [3:0] legacy_active; // port performing legacy detection
    } ptlc_status_t;

    // commands to the per-port engines
    typedef struct packed {
        logic [3:0] det_start;  // one-cycle: run one detection
        logic [3:0] cls_start;  // one-cycle: run one classification
        logic [3:0] power_on;   // one-cycle: start the port up
        logic [3:0] power_off;  // one-cycle: shut the port down
        logic [3:0] det_repeat; // level: repeat detection continuously
        logic [3:0] cls_repeat; // level: repeat classification continuously
    } ptlc_cmd_t;

    // effective legacy policy per port
    typedef struct packed {
        logic [3:0] legacy_only;  // legacy instead of standard
        logic [3:0] legacy_after; // legacy after standard
    } ptlc_legacy_t;

endpackage

// [logic/ptlc_regs.sv]
// trigger, power and legacy control register bank for four ports
module ptlc_regs #(
    parameter int unsigned TIMEOUT_CYCLES = ptlc_pkg::ON_TIMEOUT_CYCLES
) (
    // clock and reset
    input  wire logic                  clock,
    input  wire logic                  srst,
    // register access from the management bus slave
    input  wire logic                  wr_en,
    input  wire logic                  rd_en,
    input  wire logic [7:0]            addr,
    input  wire logic [7:0]            wdata,
    output logic      [7:0]            rdata,
    // configuration from the mode and enable registers
    input  wire ptlc_pkg::ptlc_mode_t  mode,
    input  wire logic [3:0]            detection_enable,
    input  wire logic [3:0]            classification_enable,
    // port engines
    input  wire ptlc_pkg::ptlc_status_t status,
    output ptlc_pkg::ptlc_cmd_t        cmd,
    output ptlc_pkg::ptlc_legacy_t     legacy
);

    // ==========================================================
    // helpers
    // set wins over clear, so a write in a done cycle is kept
    function automatic logic [3:0] set_wins(input logic [3:0] cur,
                                            input logic [3:0] set,
                                            input logic [3:0] clr);
        set_wins = (cur & ~clr) | set;
    endfunction

    // only ones are taken from a write; zeros leave bits alone
    function automatic logic [3:0] ones_of(input logic       hit,
                                           input logic [3:0] data);
        ones_of = hit ? data : ptlc_pkg::NIBBLE_ZERO;
    endfunction

    // ==========================================================
    // counter sizing, declared ahead of the counters that use it
    localparam int TMO_W_L = ptlc_pkg::TMO_W;
    localparam logic [TMO_W_L-1:0] TMO_LAST = TMO_W_L'(TIMEOUT_CYCLES - 1);
    localparam logic [TMO_W_L-1:0] TMO_ZERO = '0;

    // ==========================================================
    // state
    logic [3:0] reclassify_reg;            // reclassify_port4..1
    logic [3:0] redetect_reg;              // redetect_port4..1
    logic [3:0] power_off_reg;             // power_off_port4..1
    logic [3:0] power_on_reg;              // power_on_port4..1
    logic [7:0] legacy_detect_enable_reg;  // legacy_policy_port4..1
    logic [3:0] det_launched_reg;          // manual detection already issued
    logic [3:0] cls_launched_reg;          // manual classification already issued
    logic [3:0] on_issued_reg;             // start-up already issued
    logic [3:0] det_first_reg;             // detection owed before power-on
    logic [TMO_W_L-1:0] tmo_cnt_reg [4];   // operational lifetime counters
    ptlc_pkg::ptlc_cmd_t cmd_reg;          // registered command outputs
    logic [7:0] rdata_reg;                 // registered read data

    // ==========================================================
    // write decode
    wire hit_trig   = wr_en && (addr == ptlc_pkg::OFF_DET_CLS_TRIG);
    wire hit_power  = wr_en && (addr == ptlc_pkg::OFF_POWER_TRIG);
    wire hit_legacy = wr_en && (addr == ptlc_pkg::OFF_LEGACY_EN);

    // writes of 0 have no effect on trigger bits
    wire [3:0] set_recls = ones_of(hit_trig,
                                   wdata[ptlc_pkg::UPPER_MSB:ptlc_pkg::UPPER_LSB]); // [R01] [R17]
    wire [3:0] set_redet = ones_of(hit_trig,
                                   wdata[ptlc_pkg::LOWER_MSB:ptlc_pkg::LOWER_LSB]); // [R03] [R17]
    wire [3:0] set_off   = ones_of(hit_power,
                                   wdata[ptlc_pkg::UPPER_MSB:ptlc_pkg::UPPER_LSB]); // [R07] [R17]
    wire [3:0] set_on    = ones_of(hit_power,
                                   wdata[ptlc_pkg::LOWER_MSB:ptlc_pkg::LOWER_LSB]); // [R08] [R17]

    // ==========================================================
    // mode decode
    wire is_manual = (mode == ptlc_pkg::PTLC_MANUAL);
    wire is_semi   = (mode == ptlc_pkg::PTLC_SEMI_AUTO);
    wire is_auto   = (mode == ptlc_pkg::PTLC_AUTO);
    // the unused fourth mode code accepts no power-on and keeps the repeats

    // ==========================================================
    // detection and classification triggers
    wire [3:0] redet_next = set_wins(redetect_reg, set_redet, status.det_done);   // [R04]
    wire [3:0] recls_next = set_wins(reclassify_reg, set_recls, status.cls_done); // [R02]

    // detection owed before start-up when both were asked together
    wire [3:0] det_first_set = set_on & detection_enable;                         // [R09]
    wire [3:0] on_clear;
    wire [3:0] det_first_next = set_wins(det_first_reg, det_first_set,
                                         status.det_done | on_clear);            // [R09]

    // manual mode: one launch per set bit, never repeated
    // trade-off: one flop per port per kind, instead of counting launches
    wire [3:0] det_want   = redetect_reg | det_first_reg;
    wire [3:0] det_launch = is_manual ? (det_want & ~det_launched_reg)
                                      : ptlc_pkg::NIBBLE_ZERO;                    // [R05]
    wire [3:0] cls_launch = is_manual ? (reclassify_reg & ~cls_launched_reg)
                                      : ptlc_pkg::NIBBLE_ZERO;                    // [R05]
    // launched marks drop with the bit that caused them
    wire [3:0] det_launched_next = (det_launched_reg | det_launch)
                                   & (redet_next | det_first_next);
    wire [3:0] cls_launched_next = (cls_launched_reg | cls_launch) & recls_next;

    // other modes: the enables govern, and the engines repeat
    wire [3:0] det_repeat_next = is_manual ? ptlc_pkg::NIBBLE_ZERO
                                           : detection_enable;                    // [R06]
    wire [3:0] cls_repeat_next = is_manual ? ptlc_pkg::NIBBLE_ZERO
                                           : classification_enable;               // [R06]

    // ==========================================================
    // power-on acceptance per mode
    wire [3:0] on_ok_manual = ~status.powered & ~status.shutdown;                 // [R10]
    wire [3:0] on_ok_semi   = status.results_valid;                               // [R11]
    wire [3:0] on_ok_auto   = status.legacy_active;                               // [R12]
    wire [3:0] on_ok = is_manual ? on_ok_manual :
                       is_semi   ? on_ok_semi   :
                       is_auto   ? on_ok_auto   : ptlc_pkg::NIBBLE_ZERO;

    // issue once, and only after any owed detection has finished
    wire [3:0] on_issue = power_on_reg & ~on_issued_reg & on_ok & ~det_first_reg;  // [R08] [R09]

    // ==========================================================
    // power-on lifetime while the port is operational
    // limitation: the count restarts whenever the port drops power, so a
    // flapping port never times its request out
    logic [3:0] tmo_hit;
    logic [TMO_W_L-1:0] tmo_next [4];
    always_comb begin
        // counters run only while a request sits on a powered port
        for (int i = 0; i < ptlc_pkg::PORTS; i++) begin
            tmo_hit[i] = (tmo_cnt_reg[i] == TMO_LAST);                             // [R13]
            if (power_on_reg[i] && status.powered[i] && !tmo_hit[i]) begin
                tmo_next[i] = tmo_cnt_reg[i] + TMO_W_L'(1);
            end else begin
                tmo_next[i] = TMO_ZERO;
            end
        end
    end

    // failures, completion, timeout or a power-off end the request
    wire [3:0] fails = status.det_fail | status.cls_fail
                     | status.legacy_fail | status.start_fail;
    assign on_clear = status.start_done | fails | tmo_hit | power_off_reg;         // [R08] [R13]
    wire [3:0] on_next = set_wins(power_on_reg, set_on, on_clear);
    wire [3:0] on_issued_next = (on_issued_reg | on_issue) & on_next;

    // power-off lives one cycle unless written again
    // it also cancels a pending power-on through on_clear
    wire [3:0] off_next = set_off;                                                 // [R07]

    // ==========================================================
    // legacy policy, reserved code behaves as disabled
    // decoded every cycle from the stored byte, so a readback always matches
    logic [3:0] leg_only;
    logic [3:0] leg_after;
    always_comb begin
        // decode each two-bit field
        for (int i = 0; i < ptlc_pkg::PORTS; i++) begin
            leg_only[i]  = (legacy_detect_enable_reg[i*ptlc_pkg::LEG_W +: ptlc_pkg::LEG_W]
                            == ptlc_pkg::LEG_INSTEAD);                             // [R14] [R16]
            leg_after[i] = (legacy_detect_enable_reg[i*ptlc_pkg::LEG_W +: ptlc_pkg::LEG_W]
                            == ptlc_pkg::LEG_AFTER);                               // [R14] [R16]
        end
    end
    wire [7:0] legacy_next = hit_legacy ? wdata : legacy_detect_enable_reg;        // [R15]

    // ==========================================================
    // read mux, unknown offsets read zero
    // reads have no side effects, so polling never disturbs a trigger
    wire [7:0] rd_mux =
        (addr == ptlc_pkg::OFF_DET_CLS_TRIG) ? {reclassify_reg, redetect_reg} :
        (addr == ptlc_pkg::OFF_POWER_TRIG)   ? {power_off_reg, power_on_reg}   :
        (addr == ptlc_pkg::OFF_LEGACY_EN)    ? legacy_detect_enable_reg        :
                                               ptlc_pkg::READ_UNMAPPED;

    // ==========================================================
    // command assembly
    // every command leaves through a flop, so engines never see decode glitches
    ptlc_pkg::ptlc_cmd_t cmd_next;
    assign cmd_next.det_start  = det_launch;
    assign cmd_next.cls_start  = cls_launch;
    assign cmd_next.power_on   = on_issue;
    assign cmd_next.power_off  = set_off;
    assign cmd_next.det_repeat = det_repeat_next;
    assign cmd_next.cls_repeat = cls_repeat_next;

    // ==========================================================
    // registers
    // trigger and legacy fields, all reset to zero
    always_ff @(posedge clock) begin
        if (srst) begin
            {reclassify_reg, redetect_reg} <= ptlc_pkg::RESET_BYTE;
            {power_off_reg, power_on_reg}  <= ptlc_pkg::RESET_BYTE;
            legacy_detect_enable_reg       <= ptlc_pkg::RESET_BYTE;                // [R15]
        end else begin
            reclassify_reg           <= recls_next;
            redetect_reg             <= redet_next;
            power_off_reg            <= off_next;
            power_on_reg             <= on_next;
            legacy_detect_enable_reg <= legacy_next;
        end
    end

    // bookkeeping flags
    always_ff @(posedge clock) begin
        if (srst) begin
            det_launched_reg <= ptlc_pkg::NIBBLE_ZERO;
            cls_launched_reg <= ptlc_pkg::NIBBLE_ZERO;
            on_issued_reg    <= ptlc_pkg::NIBBLE_ZERO;
            det_first_reg    <= ptlc_pkg::NIBBLE_ZERO;
        end else begin
            det_launched_reg <= det_launched_next;
            cls_launched_reg <= cls_launched_next;
            on_issued_reg    <= on_issued_next;
            det_first_reg    <= det_first_next;
        end
    end

    // lifetime counters
    always_ff @(posedge clock) begin
        for (int i = 0; i < ptlc_pkg::PORTS; i++) begin
            tmo_cnt_reg[i] <= srst ? TMO_ZERO : tmo_next[i];
        end
    end

    // outputs and read data
    always_ff @(posedge clock) begin
        if (srst) begin
            cmd_reg   <= '0;
            rdata_reg <= ptlc_pkg::READ_UNMAPPED;
        end else begin
            cmd_reg <= cmd_next;
            if (rd_en) begin
                rdata_reg <= rd_mux;
            end
        end
    end

    assign cmd                 = cmd_reg;
    assign rdata               = rdata_reg;
    assign legacy.legacy_only  = leg_only;
    assign legacy.legacy_after = leg_after;

    // ==========================================================
    // assertions
    wire wr_det0 = hit_trig && wdata[ptlc_pkg::LOWER_LSB];
    wire wr_cls3 = hit_trig && wdata[ptlc_pkg::UPPER_MSB];
    wire wr_on0  = hit_power && wdata[ptlc_pkg::LOWER_LSB];

    // trigger bits: taken on write, dropped on done
    a_redet_set: assert property (@(posedge clock) disable iff (srst) // [R03]
        wr_det0 |=> redetect_reg[0]) else $error("redetect write not taken");
    a_recls_set: assert property (@(posedge clock) disable iff (srst) // [R01]
        wr_cls3 |=> reclassify_reg[3]) else $error("reclassify write not taken");
    a_redet_clear: assert property (@(posedge clock) disable iff (srst) // [R04]
        (status.det_done[0] && !wr_det0) |=> !redetect_reg[0])
        else $error("redetect not cleared on done");
    a_recls_clear: assert property (@(posedge clock) disable iff (srst) // [R02]
        (status.cls_done[3] && !wr_cls3) |=> !reclassify_reg[3])
        else $error("reclassify not cleared on done");

    // launches, repeats and the power-off pulse
    a_manual_once: assert property (@(posedge clock) disable iff (srst) // [R05]
        cmd.det_start[0] |-> !$past(cmd.det_start[0]) && $past(is_manual))
        else $error("manual detection launched twice or outside manual");
    a_repeat_follow: assert property (@(posedge clock) disable iff (srst) // [R06]
        !is_manual |=> cmd.det_repeat == $past(detection_enable) && cmd.det_start == 4'h0)
        else $error("repeat does not follow enable");
    a_off_pulse: assert property (@(posedge clock) disable iff (srst) // [R07]
        (hit_power && wdata[ptlc_pkg::UPPER_LSB]) |=> power_off_reg[0] && cmd.power_off[0])
        else $error("power-off not issued");

    // power-on acceptance and clearing
    a_on_done_clear: assert property (@(posedge clock) disable iff (srst) // [R08]
        (status.start_done[0] && !wr_on0) |=> !power_on_reg[0])
        else $error("power-on not cleared after start-up");
    a_det_first: assert property (@(posedge clock) disable iff (srst) // [R09]
        det_first_reg[0] |=> !cmd.power_on[0]) else $error("power-on before detection");
    a_manual_block: assert property (@(posedge clock) disable iff (srst) // [R10]
        (is_manual && (status.powered[0] || status.shutdown[0])) |=> !cmd.power_on[0])
        else $error("manual power-on on busy port");
    a_semi_valid: assert property (@(posedge clock) disable iff (srst) // [R11]
        (is_semi && !status.results_valid[0]) |=> !cmd.power_on[0])
        else $error("semi power-on without valid results");
    a_auto_legacy: assert property (@(posedge clock) disable iff (srst) // [R12]
        (is_auto && !status.legacy_active[0]) |=> !cmd.power_on[0])
        else $error("auto power-on outside legacy detection");
    a_fail_clear: assert property (@(posedge clock) disable iff (srst) // [R13]
        (fails[0] && !wr_on0) |=> !power_on_reg[0]) else $error("failure kept power-on");

    // legacy decode and reset
    a_legacy_code: assert property (@(posedge clock) disable iff (srst) // [R14]
        (legacy_detect_enable_reg[1:0] == ptlc_pkg::LEG_INSTEAD) |-> legacy.legacy_only[0]
        && !legacy.legacy_after[0]) else $error("legacy code misdecoded");
    a_legacy_rsvd: assert property (@(posedge clock) disable iff (srst) // [R16]
        (legacy_detect_enable_reg[7:6] == ptlc_pkg::LEG_RESERVED) |->
        !legacy.legacy_only[3] && !legacy.legacy_after[3]) else $error("reserved code active");
    a_legacy_reset: assert property (@(posedge clock) // [R15]
        srst |=> legacy_detect_enable_reg == ptlc_pkg::RESET_BYTE)
        else $error("legacy field not reset");

endmodule

// [test/ptlc_engine_model.sv]
// behavioural port engines that answer the register bank's commands
module ptlc_engine_model (
    // clock and reset
    input  wire logic                   clock,
    input  wire logic                   srst,
    // commands from the bank, levels chosen by the bench
    input  wire ptlc_pkg::ptlc_cmd_t    cmd,
    input  wire logic [3:0]             rv_level,
    input  wire logic [3:0]             legacy_level,
    input  wire logic [3:0]             fail_level,
    // status back to the bank
    output ptlc_pkg::ptlc_status_t      status
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // state
    logic [11:0] run1, run2;   // two-stage run of detect, classify, start
    logic [3:0]  powered_reg;  // port carries power
    // done pulses come two cycles after a start; a real engine may be slower
    always_ff @(posedge clock) begin
        if (srst) begin
            run1 <= 12'h000;
            run2 <= 12'h000;
            powered_reg <= 4'h0;
        end else begin
            run1 <= {cmd.det_start, cmd.cls_start, cmd.power_on};
            run2 <= run1;
            powered_reg <= (powered_reg | run2[3:0]) & ~cmd.power_off;
        end
    end
    // ==========================================================
    // status assembly, start failures from the bench, other failures idle
    assign status = '{det_done: run2[11:8], cls_done: run2[7:4], start_done: run2[3:0],
                      powered: powered_reg, results_valid: rv_level,
                      legacy_active: legacy_level, start_fail: fail_level, default: 4'h0};
endmodule

// [test/tb_top.sv]
// self-checking bench for the port trigger and legacy control bank
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic [7:0] a, d, r; logic [3:0] lo, la;} ptlc_row_t;
    logic                   clock = 1'b0, srst = 1'b1, wr_en = 1'b0, rd_en = 1'b0;
    logic [7:0]             addr = 8'h00, wdata = 8'h00, rdata, rd_val;
    ptlc_pkg::ptlc_mode_t   mode = ptlc_pkg::PTLC_MANUAL;
    logic [3:0]             det_en = 4'h0, cls_en = 4'h0, rv = 4'h0, la = 4'h0, sf = 4'h0;
    ptlc_pkg::ptlc_status_t status;
    ptlc_pkg::ptlc_cmd_t    cmd;
    ptlc_pkg::ptlc_legacy_t legacy;
    int                     err_count = 0, checked = 0, cyc = 0, t_det = 0, t_on = 0;
    logic [7:0]             n_det, n_cls, n_on, n_off; // pulse counts per window
    ptlc_row_t              rows [5] = '{'{8'h10, 8'h00, 8'h00, 4'h0, 4'h0},
        '{8'h12, 8'h1b, 8'h1b, 4'h4, 4'h2}, '{8'h12, 8'he4, 8'he4, 4'h2, 4'h4},
        '{8'h12, 8'h00, 8'h00, 4'h0, 4'h0}, '{8'h13, 8'hff, 8'h00, 4'h0, 4'h0}};
    // ==========================================================
    // design and engine model
    ptlc_regs #(.TIMEOUT_CYCLES(16)) dut (.clock(clock), .srst(srst), .wr_en(wr_en),
        .rd_en(rd_en), .addr(addr), .wdata(wdata), .rdata(rdata), .mode(mode),
        .detection_enable(det_en), .classification_enable(cls_en), .status(status),
        .cmd(cmd), .legacy(legacy));
    ptlc_engine_model eng (.clock(clock), .srst(srst), .cmd(cmd), .rv_level(rv),
        .legacy_level(la), .fail_level(sf), .status(status));
    always #20 clock = ~clock;
    // pulse counters; latest pulse times give the detect-then-power order
    always @(posedge clock) begin
        cyc++;
        n_det += 8'($countones(cmd.det_start));
        n_cls += 8'($countones(cmd.cls_start));
        n_on += 8'($countones(cmd.power_on));
        n_off += 8'($countones(cmd.power_off));
        if (cmd.det_start[0] === 1'b1) t_det = cyc;
        if (cmd.power_on[0] === 1'b1) t_on = cyc;
    end
    // ==========================================================
    // shared tasks
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic clr();
        n_det = 8'h00;
        n_cls = 8'h00;
        n_on = 8'h00;
        n_off = 8'h00;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        wr_en <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clock);
        wr_en <= 1'b0;
    endtask
    // rdata is registered at the edge that samples rd_en; taken one edge later
    task automatic rd(input logic [7:0] a);
        @(posedge clock);
        rd_en <= 1'b1;
        addr <= a;
        @(posedge clock);
        rd_en <= 1'b0;
        @(posedge clock);
        rd_val = rdata;
    endtask
    task automatic pause(input int n);
        repeat (n) @(posedge clock);
    endtask
    task automatic conclude();
        $display("mismatches %0d, comparisons %0d", err_count, checked);
        if (err_count == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // watchdog, well beyond the expected 165 or so cycles
    initial begin
        pause(3000);
        err_count++;
        conclude();
    end
    // ==========================================================
    // main sequence
    initial begin
        clr();
        pause(2);
        srst <= 1'b0;
        for (int i = 0; i < 3; i++) begin
            rd(8'h10 + 8'(i));
            check(rd_val, 8'h00);
        end
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            rd(rows[i].a);
            check(rd_val, rows[i].r);
            check({4'h0, legacy.legacy_only}, {4'h0, rows[i].lo});
            check({4'h0, legacy.legacy_after}, {4'h0, rows[i].la});
        end
        // manual: one detection on port 1, one classification on port 4
        clr();
        wr(8'h10, 8'h81);
        pause(12);
        check(n_det, 8'h01);
        check(n_cls, 8'h01);
        rd(8'h10);
        check(rd_val, 8'h00);
        // power-off pulse and self-clear
        wr(8'h11, 8'h10);
        pause(6);
        check(n_off, 8'h01);
        rd(8'h11);
        check(rd_val, 8'h00);
        // power-on with detection enabled: detection comes first
        det_en <= 4'h1;
        clr();
        wr(8'h11, 8'h01);
        pause(15);
        check(n_on, 8'h01);
        check(8'(t_on > t_det), 8'h01);
        rd(8'h11);
        check(rd_val, 8'h00);
        // already powered: ignored, then the persistence timeout clears it
        det_en <= 4'h0;
        clr();
        wr(8'h11, 8'h01);
        pause(8);
        rd(8'h11);
        check(rd_val, 8'h01);
        pause(20);
        rd(8'h11);
        check(rd_val, 8'h00);
        check(n_on, 8'h00);
        // semi-automatic: held until results are valid; repeat follows enables
        mode <= ptlc_pkg::PTLC_SEMI_AUTO;
        det_en <= 4'h5;
        cls_en <= 4'ha;
        wr(8'h11, 8'h02);
        pause(6);
        check(n_on, 8'h00);
        check({cmd.det_repeat, cmd.cls_repeat}, 8'h5a);
        rv <= 4'h2;
        pause(6);
        check(n_on, 8'h01);
        // automatic: only while legacy detection runs
        mode <= ptlc_pkg::PTLC_AUTO;
        det_en <= 4'h0;
        clr();
        wr(8'h11, 8'h04);
        pause(6);
        check(n_on, 8'h00);
        la <= 4'h4;
        pause(6);
        check(n_on, 8'h01);
        // a start failure drops a held power-on long before the timeout
        wr(8'h11, 8'h01);
        rd(8'h11);
        check(rd_val, 8'h01);
        sf <= 4'h1;
        pause(1);
        sf <= 4'h0;
        rd(8'h11);
        check(rd_val, 8'h00);
        // mid-run reset clears a written legacy field
        wr(8'h12, 8'h55);
        pause(1);
        check({legacy.legacy_only, legacy.legacy_after}, 8'hf0);
        srst <= 1'b1;
        pause(2);
        srst <= 1'b0;
        rd(8'h12);
        check(rd_val, 8'h00);
        check({legacy.legacy_only, legacy.legacy_after}, 8'h00);
        conclude();
    end
endmodule
